/* rtl/mic_pkg.sv */
// Function
// - exactly four request sources accepted
// - global enable at control bit 7
// - reset clears global enable
// - return-from-irq sets global enable again
// - accept: clear enable, push, vector 0004h
// - external event latency three to four cycles
// - flags set regardless of any enable
// - three flags readable in control register
// - external pin edge chosen by option bit 6
// - selected edge sets control bit 1
// - control bit 4 masks external interrupt
// - pin wakes sleep only if enabled
// - timer FFh to 00h sets bit 2
// - control bit 5 enables timer interrupt
// - port change sets bit 0, enable bit 3
// - memory write done flag, enable bit 6
// - enabled event wakes regardless of global enable
package mic_pkg;
    localparam int NSRC = 4;
    localparam logic [15:0] VECTOR_ADDR = 16'h0004;
    localparam int GIE_BIT = 7;
    localparam int NVME_BIT = 6;
    localparam int TIME_BIT = 5;
    localparam int EXTE_BIT = 4;
    localparam int PCHE_BIT = 3;
    localparam int TIMF_BIT = 2;
    localparam int EXTF_BIT = 1;
    localparam int PCHF_BIT = 0;
    localparam int NVMF_BIT = 4;
    localparam int EDGE_BIT = 6;
    localparam logic [7:0] TIMER_MAX = 8'hFF;
    localparam logic [7:0] TIMER_ZERO = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] OPT_RST = 8'hFF;
    // axi byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_OPT = 8'h04;
    localparam logic [7:0] A_NVM = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0C;
    localparam logic [7:0] A_CLR = 8'h10;
    localparam logic [7:0] A_IEN = 8'h14;
    localparam logic [7:0] A_CORE = 8'h18;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // core status event bits
    localparam int EV_ACCEPT = 0;
    localparam int EV_WAKE = 1;
    localparam int EV_RETURN = 2;
    localparam int NEV = 3;
    // last ref_clk count of the four-cycle instruction cycle
    localparam logic [1:0] QCLKS = 2'h3;
endpackage

/* rtl/mic_sync.sv */
`timescale 1ns/1ps
module mic_sync
    import mic_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    mic_sync_if.sync s
);
    typedef struct packed {
        logic [5:0] s1;
        logic [5:0] s2;
        logic [5:0] s3;
        logic [5:0] q;
    } mic_sync_st_t;
    mic_sync_st_t st_reg, st_next;
    always_comb begin
        st_next = st_reg;
        st_next.s1 = s.raw;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        // only agreed levels pass, one glitch never counts
        for (int i = 0; i < 6; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.q[i] = st_reg.s3[i];
            end
        end
    end
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end
    assign s.clean = st_reg.q;
endmodule

/* rtl/mic_sync_if.sv */
`timescale 1ns/1ps
interface mic_sync_if;
    logic [5:0] raw;
    logic [5:0] clean;
    modport owner (output raw, input clean);
    modport sync (input raw, output clean);
endinterface

/* rtl/mic_top.sv */
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module mic_top
    import mic_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic ext_irq_pin,
    input wire logic [3:0] port_hi_pins,
    input wire logic nvm_write_done,
    input wire logic [7:0] timer_counter_reg,
    input wire logic [15:0] core_pc,
    input wire logic core_sleep,
    input wire logic return_from_irq_op,
    input wire logic core_ack,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic core_irq_req,
    output logic core_wake,
    output logic core_vector_load,
    output logic [15:0] core_vector,
    output logic stack_push,
    output logic [15:0] stack_push_data,
    output logic irq_out
);
    typedef enum logic [1:0] {
        IDLE,
        WAIT_Q,
        VECT
    } mic_state_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] opt;
        logic nvm_flag;
        logic [NEV-1:0] stat;
        logic [NEV-1:0] ien;
        logic ext_prev;
        logic [3:0] port_prev;
        logic [7:0] tmr_prev;
        logic nvm_prev;
        logic primed;
        logic [1:0] qcnt;
        logic [2:0] lat;
        mic_state_t state;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic irq_req;
        logic wake;
        logic vload;
        logic push;
        logic [15:0] push_pc;
        logic irq;
    } mic_st_t;

    mic_st_t st_reg, st_next;
    mic_sync_if sif();

    assign sif.raw = {nvm_write_done, port_hi_pins, ext_irq_pin};

    mic_sync u_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ce(clk_en),
        .s(sif)
    );

    logic ext_now;
    logic [3:0] port_now;
    logic nvm_now;
    logic ext_edge;
    logic port_chg;
    logic nvm_done;
    logic tmr_ovf;
    logic [NSRC-1:0] pend;
    logic any_pend;
    logic [7:0] rd_word;
    logic rd_ok;
    logic wr_go;
    logic rd_go;
    logic [NEV-1:0] ev;

    assign ext_now = sif.clean[0];
    assign port_now = sif.clean[4:1];
    assign nvm_now = sif.clean[5];

    always_comb begin
        // rising or falling per edge select
        ext_edge = st_reg.primed && (st_reg.opt[EDGE_BIT] ?
            (ext_now && !st_reg.ext_prev) : (!ext_now && st_reg.ext_prev));
        port_chg = st_reg.primed && (port_now != st_reg.port_prev);
        nvm_done = st_reg.primed && nvm_now && !st_reg.nvm_prev;
        tmr_ovf = st_reg.primed && (st_reg.tmr_prev == TIMER_MAX) &&
            (timer_counter_reg == TIMER_ZERO);
        // the four sources, each flag paired with its enable
        pend[0] = st_reg.ctrl[EXTF_BIT] && st_reg.ctrl[EXTE_BIT];
        pend[1] = st_reg.ctrl[TIMF_BIT] && st_reg.ctrl[TIME_BIT];
        pend[2] = st_reg.ctrl[PCHF_BIT] && st_reg.ctrl[PCHE_BIT];
        pend[3] = st_reg.nvm_flag && st_reg.ctrl[NVME_BIT];
        any_pend = |pend;
        wr_go = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
        rd_go = s_axi_arvalid && !st_reg.rvalid;
        rd_ok = 1'b1;
        rd_word = 8'h00;
        unique case (s_axi_araddr)
            A_CTRL: rd_word = st_reg.ctrl;
            A_OPT: rd_word = st_reg.opt;
            A_NVM: rd_word = {3'h0, st_reg.nvm_flag, 4'h0};
            A_STAT: rd_word = {5'h00, st_reg.stat};
            A_IEN: rd_word = {5'h00, st_reg.ien};
            A_CLR: rd_word = 8'h00;
            A_CORE: rd_word = {4'h0, core_sleep, 1'b0, st_reg.state == IDLE, st_reg.irq_req};
            default: rd_ok = 1'b0;
        endcase
    end

    always_comb begin
        st_next = st_reg;
        ev = '0;
        st_next.primed = 1'b1;
        st_next.ext_prev = ext_now;
        st_next.port_prev = port_now;
        st_next.nvm_prev = nvm_now;
        st_next.tmr_prev = timer_counter_reg;
        st_next.vload = 1'b0;
        st_next.push = 1'b0;
        st_next.qcnt = (st_reg.qcnt == QCLKS) ? 2'h0 : st_reg.qcnt + 2'h1;

        // axi write channel capture
        if (s_axi_awvalid && !st_reg.aw_got) begin
            st_next.aw_got = 1'b1;
            st_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.w_got) begin
            st_next.w_got = 1'b1;
            st_next.wdata = s_axi_wdata;
            st_next.wstrb = s_axi_wstrb;
        end
        if (wr_go) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = RESP_OK;
            if (st_reg.wstrb[0]) begin
                unique case (st_reg.awaddr)
                    A_CTRL: st_next.ctrl = st_reg.wdata[7:0];
                    A_OPT: st_next.opt = st_reg.wdata[7:0];
                    A_NVM: st_next.nvm_flag = st_reg.wdata[NVMF_BIT];
                    A_CLR: st_next.stat = st_reg.stat & ~st_reg.wdata[NEV-1:0];
                    A_IEN: st_next.ien = st_reg.wdata[NEV-1:0];
                    A_STAT, A_CORE: st_next.bresp = RESP_OK;
                    default: st_next.bresp = RESP_SLVERR;
                endcase
            end
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (rd_go) begin
            st_next.rvalid = 1'b1;
            st_next.rdata = {24'h000000, rd_word};
            st_next.rresp = rd_ok ? RESP_OK : RESP_SLVERR;
        end else if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end

        // hardware sets follow software writes, so sets win
        if (ext_edge) st_next.ctrl[EXTF_BIT] = 1'b1;
        if (tmr_ovf) st_next.ctrl[TIMF_BIT] = 1'b1;
        if (port_chg) st_next.ctrl[PCHF_BIT] = 1'b1;
        if (nvm_done) st_next.nvm_flag = 1'b1;

        if (return_from_irq_op) begin
            st_next.ctrl[GIE_BIT] = 1'b1;
            ev[EV_RETURN] = 1'b1;
        end

        // wake needs an enabled pending event only, gie not involved
        st_next.wake = core_sleep && any_pend;
        if (core_sleep && any_pend && !st_reg.wake) ev[EV_WAKE] = 1'b1;

        st_next.irq_req = st_reg.ctrl[GIE_BIT] && any_pend;

        // acceptance aligned to instruction cycle boundaries
        unique case (st_reg.state)
            IDLE: begin
                if (st_reg.irq_req && !core_sleep && st_reg.ctrl[GIE_BIT]) begin
                    st_next.state = WAIT_Q;
                    st_next.lat = 3'h0;
                end
            end
            WAIT_Q: begin
                // two boundaries plus sync gives three to four cycles
                if (st_reg.qcnt == QCLKS) begin
                    st_next.lat = st_reg.lat + 3'h1;
                    if (st_reg.lat == 3'h1) st_next.state = VECT;
                end
                if (!st_reg.ctrl[GIE_BIT]) st_next.state = IDLE;
            end
            VECT: begin
                st_next.ctrl[GIE_BIT] = 1'b0;
                st_next.push = 1'b1;
                st_next.push_pc = core_pc;
                st_next.vload = 1'b1;
                st_next.irq_req = 1'b0;
                ev[EV_ACCEPT] = 1'b1;
                st_next.state = IDLE;
            end
        endcase
        if (core_ack) st_next.irq_req = 1'b0;

        st_next.stat = st_next.stat | ev;
        st_next.irq = |(st_next.stat & st_reg.ien);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
            st_reg.ctrl <= CTRL_RST;
            st_reg.opt <= OPT_RST;
            st_reg.state <= IDLE;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready = !st_reg.aw_got;
    assign s_axi_wready = !st_reg.w_got;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
    assign core_irq_req = st_reg.irq_req;
    assign core_wake = st_reg.wake;
    assign core_vector_load = st_reg.vload;
    assign core_vector = st_reg.vload ? VECTOR_ADDR : 16'h0000;
    assign stack_push = st_reg.push;
    assign stack_push_data = st_reg.push_pc;
    assign irq_out = st_reg.irq;
endmodule

/* tb/mic_core_model.sv */
`timescale 1ns/1ps
module mic_core_model
    import mic_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic core_vector_load,
    input wire logic core_wake,
    input wire logic sleep_cmd,
    input wire logic ret_cmd,
    output logic [15:0] core_pc,
    output logic core_sleep,
    output logic return_from_irq_op,
    output logic core_ack
);
    // pc parked so the pushed address is predictable
    localparam logic [15:0] MAIN_PC = 16'h0123;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            core_pc <= MAIN_PC;
            core_sleep <= 1'b0;
            return_from_irq_op <= 1'b0;
            core_ack <= 1'b0;
        end else begin
            core_ack <= core_vector_load;
            return_from_irq_op <= ret_cmd;
            if (core_vector_load) core_pc <= VECTOR_ADDR;
            else if (return_from_irq_op) core_pc <= MAIN_PC;
            if (sleep_cmd) core_sleep <= 1'b1;
            else if (core_wake) core_sleep <= 1'b0;
        end
    end
endmodule

/* tb/mic_props.sv */
`timescale 1ns/1ps
module mic_props
    import mic_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [15:0] core_pc,
    input wire logic core_sleep,
    input wire logic return_from_irq_op,
    input wire logic core_irq_req,
    input wire logic core_wake,
    input wire logic core_vector_load,
    input wire logic [15:0] core_vector,
    input wire logic stack_push,
    input wire logic [15:0] stack_push_data
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_vector_fixed: assert property (
        core_vector_load |-> core_vector == VECTOR_ADDR && stack_push)
        else $error("vector or push wrong at accept");
    a_vector_idle: assert property (
        !core_vector_load |-> core_vector == 16'h0000)
        else $error("vector driven outside accept");
    a_push_pc: assert property (
        stack_push |-> stack_push_data == $past(core_pc))
        else $error("pushed return address wrong");
    a_accept_pulse: assert property (
        core_vector_load |=> !core_vector_load)
        else $error("accept pulse longer than one cycle");
    a_accept_gated: assert property (
        core_vector_load |-> $past(core_irq_req))
        else $error("accept without request");
    a_gie_dropped: assert property (
        core_vector_load ##1 !return_from_irq_op [*2] |-> !core_irq_req)
        else $error("request survives accept");
    a_reset_quiet: assert property (
        $rose(rst_b) |-> !core_irq_req [*3])
        else $error("request right after reset");
    a_wake_asleep: assert property (
        core_wake |-> $past(core_sleep))
        else $error("wake while awake");
endmodule
bind mic_top mic_props u_props (.*);

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top import mic_pkg::*;;
    logic ref_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, ext_irq_pin = 1'b0;
    logic [3:0] port_hi_pins = 4'h0, s_axi_wstrb = 4'hF;
    logic nvm_write_done = 1'b0, sleep_cmd = 1'b0, ret_cmd = 1'b0;
    logic [7:0] timer_counter_reg = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd_data;
    logic [15:0] core_pc, core_vector, stack_push_data;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
    logic core_sleep, return_from_irq_op, core_ack, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, core_irq_req, core_wake;
    logic core_vector_load, stack_push, irq_out;
    int bad_count = 0, cmp_count = 0, cyc = 0, vec_count = 0;
    always #10 ref_clk = ~ref_clk;
    mic_top DUT (.*);
    mic_core_model u_core (.*);
    task automatic summarize();
        if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (core_vector_load === 1'b1) vec_count++;
        if (cyc == 20000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk("rdata", {24'h000000, e}, rd_data);
    endtask
    // bounded wait, leaves caller in the edge that showed the pulse
    task automatic wv(input int lim);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (core_vector_load !== 1'b1 && n < lim);
    endtask
    task automatic pulse_cmd(input logic ret);
        if (ret) ret_cmd <= 1'b1;
        else sleep_cmd <= 1'b1;
        @(posedge ref_clk);
        ret_cmd <= 1'b0;
        sleep_cmd <= 1'b0;
    endtask
    task automatic t_reset();
        rc(A_CTRL, CTRL_RST);
        rc(A_OPT, OPT_RST);
        rd(8'h1C);
        chk("resp", 32'(RESP_SLVERR), 32'(rd_resp));
    endtask
    task automatic t_timer();
        timer_counter_reg <= TIMER_MAX;
        repeat (2) @(posedge ref_clk);
        timer_counter_reg <= TIMER_ZERO;
        rc(A_CTRL, 8'h04);
        chk("req", 32'h0, 32'(core_irq_req));
        wr(A_CTRL, 8'hA4);
        wv(24);
        chk("vector", 32'(VECTOR_ADDR), 32'(core_vector));
        chk("push", 32'h0123, 32'(stack_push_data));
        rc(A_CTRL, 8'h24);
        chk("irq_out", 32'h0, 32'(irq_out));
        rc(A_STAT, 8'h01);
        wr(A_IEN, 8'h01);
        repeat (3) @(posedge ref_clk);
        chk("irq_out", 32'h1, 32'(irq_out));
        wr(A_CLR, 8'h07);
        repeat (3) @(posedge ref_clk);
        chk("irq_out", 32'h0, 32'(irq_out));
        wr(A_CTRL, 8'h20);
        pulse_cmd(1'b1);
        rc(A_CTRL, 8'hA0);
    endtask
    task automatic t_ext(input logic pol);
        ext_irq_pin <= pol;
        repeat (8) @(posedge ref_clk);
        wr(A_OPT, pol ? 8'hFF : 8'hBF);
        wr(A_CTRL, 8'h80);
        ext_irq_pin <= !pol;
        repeat (8) @(posedge ref_clk);
        rc(A_CTRL, 8'h80);
        ext_irq_pin <= pol;
        repeat (8) @(posedge ref_clk);
        rc(A_CTRL, 8'h82);
        chk("req", 32'h0, 32'(core_irq_req));
        wr(A_CTRL, 8'h90);
        ext_irq_pin <= !pol;
        repeat (8) @(posedge ref_clk);
        ext_irq_pin <= pol;
        // sync, flag, request and two boundaries can take up to 17 edges
        wv(24);
        chk("vector", 32'(VECTOR_ADDR), 32'(core_vector));
    endtask
    task automatic t_sleep();
        int v;
        wr(A_CTRL, 8'h00);
        port_hi_pins <= 4'h5;
        repeat (8) @(posedge ref_clk);
        rc(A_CTRL, 8'h01);
        pulse_cmd(1'b0);
        repeat (8) @(posedge ref_clk);
        chk("asleep", 32'h1, 32'(core_sleep));
        v = vec_count;
        wr(A_CTRL, 8'h40);
        nvm_write_done <= 1'b1;
        repeat (12) @(posedge ref_clk);
        rc(A_NVM, 8'h10);
        chk("asleep", 32'h0, 32'(core_sleep));
        repeat (20) @(posedge ref_clk);
        chk("accepts", 32'(v), 32'(vec_count));
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_reset();
        t_timer();
        t_ext(1'b1);
        t_ext(1'b0);
        t_sleep();
        summarize();
    end
endmodule
